// ---- rtl/pep_irq_enable_priority.sv ----
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "pep_cfg.svh"

// Behaviour
// RULE1 - Enable bit one passes, zero blocks source
// RULE2 - Priority one high level, zero low
// RULE3 - Priority bits matter only with levels on
// RULE4 - Three eight-bit priority registers cover sources
// RULE5 - Reset: enables clear, priorities set
// RULE6 - Software keeps enable-two bit 4 zero
// RULE7 - Software keeps priority-two bit 4 one
// RULE8 - Bit 2 of enable/priority two reads zero
// RULE9 - Serial port two bits only largest package
// RULE10 - Async port two bits on larger packages
// RULE11 - Parallel slave priority: largest, controller mode
// RULE12 - Enable-two bit layout as documented
// RULE13 - Enable-three bit layout as documented
// RULE14 - Priority-one bit layout as documented
// RULE15 - Priority-two mirrors enable-two layout
// RULE16 - Priority-three mirrors enable-three layout
// RULE17 - Levels-on bit 7 resets zero, legacy
// RULE18 - Request needs flag and enable, routed
// RULE19 - Absent bits read zero, ignore writes
module pep_irq_enable_priority #(
    parameter int PIN_COUNT = 100
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port
    input  wire pep_pkg::pep_bus_req_t busReq,
    output logic [7:0]             rdata_ff,
    // Peripheral side
    input  wire pep_pkg::pep_src_t srcFlags,
    input  wire logic [7:0]        enableOne,
    input  wire logic              controllerMode,
    // Core side
    output logic                   reqHigh_ff,
    output logic                   reqLow_ff,
    output logic                   levelsOn_ff,
    output logic                   irq_ff
);
    import pep_pkg::*;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (PIN_COUNT != 64 && PIN_COUNT != 80 && PIN_COUNT != 100) begin : gBadPins
        $error("PIN_COUNT must be 64, 80 or 100");
    end

    if ((`PEP_MASK_TWO & 8'h14) != 8'h10) begin : gBadMaskTwo
        $error("Enable-two mask must keep bit 4 and drop bit 2");
    end

    if ((`PEP_MASK_ONE_BASE & `PEP_MASK_ONE_PSP) != 8'h00) begin : gBadMaskOne
        $error("Priority-one masks must not overlap");
    end

    // ----------------------------------------
    // Implemented-bit masks
    // ----------------------------------------
    function automatic logic [7:0] maskThree(input int pins);
        logic [7:0] m;
        m = `PEP_MASK_THREE_BASE;
        if (pins >= 80) begin
            m = m | `PEP_MASK_THREE_80;  // [RULE10]
        end
        if (pins >= 100) begin
            m = m | `PEP_MASK_THREE_100; // [RULE9]
        end
        return m;
    endfunction

    function automatic logic [7:0] maskOne(input int pins, input logic mcu);
        logic [7:0] m;
        m = `PEP_MASK_ONE_BASE;
        if (pins >= 100 && mcu) begin
            m = m | `PEP_MASK_ONE_PSP;   // [RULE11]
        end
        return m;
    endfunction

    // Masked write keeps absent bits at their current value
    function automatic logic [7:0] maskedWrite(input logic [7:0] old, input logic [7:0] wd,
                                               input logic [7:0] m);
        return (wd & m) | (old & ~m);
    endfunction

    localparam logic [7:0] MASK_TWO   = `PEP_MASK_TWO;
    localparam logic [7:0] MASK_THREE = maskThree(PIN_COUNT);

    logic [7:0] maskOneNow;
    assign maskOneNow = maskOne(PIN_COUNT, controllerMode);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] enTwo_ff;
    logic [7:0] enThree_ff;
    logic [7:0] prioOne_ff;
    logic [7:0] prioTwo_ff;
    logic [7:0] prioThree_ff;
    logic [2:0] status_ff;
    logic [2:0] mask_ff;

    logic wrEnTwo;
    logic wrEnThree;
    logic wrPrioOne;
    logic wrPrioTwo;
    logic wrPrioThree;
    logic wrCtrl;
    logic wrStatus;
    logic wrMask;

    assign wrEnTwo     = busReq.wr && busReq.addr == `PEP_OFF_EN_TWO;
    assign wrEnThree   = busReq.wr && busReq.addr == `PEP_OFF_EN_THREE;
    assign wrPrioOne   = busReq.wr && busReq.addr == `PEP_OFF_PRIO_ONE;
    assign wrPrioTwo   = busReq.wr && busReq.addr == `PEP_OFF_PRIO_TWO;
    assign wrPrioThree = busReq.wr && busReq.addr == `PEP_OFF_PRIO_THREE;
    assign wrCtrl      = busReq.wr && busReq.addr == `PEP_OFF_RESET_CAUSE;
    assign wrStatus    = busReq.wr && busReq.addr == `PEP_OFF_STATUS;
    assign wrMask      = busReq.wr && busReq.addr == `PEP_OFF_MASK;

    // Enable registers, cleared at reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enTwo_ff   <= `PEP_RST_ENABLE;   // [RULE5]
            enThree_ff <= `PEP_RST_ENABLE;   // [RULE5]
        end else begin
            if (wrEnTwo) begin
                enTwo_ff <= maskedWrite(enTwo_ff, busReq.wdata, MASK_TWO);       // [RULE8] [RULE12]
            end
            if (wrEnThree) begin
                enThree_ff <= maskedWrite(enThree_ff, busReq.wdata, MASK_THREE); // [RULE13] [RULE19]
            end
        end
    end

    // Priority registers, set at reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prioOne_ff   <= `PEP_RST_PRIO;   // [RULE5] [RULE4]
            prioTwo_ff   <= `PEP_RST_PRIO;   // [RULE5]
            prioThree_ff <= `PEP_RST_PRIO;   // [RULE5]
        end else begin
            if (wrPrioOne) begin
                prioOne_ff <= maskedWrite(prioOne_ff, busReq.wdata, maskOneNow);       // [RULE14] [RULE11]
            end
            if (wrPrioTwo) begin
                prioTwo_ff <= maskedWrite(prioTwo_ff, busReq.wdata, MASK_TWO);         // [RULE15] [RULE8]
            end
            if (wrPrioThree) begin
                prioThree_ff <= maskedWrite(prioThree_ff, busReq.wdata, MASK_THREE);   // [RULE16] [RULE19]
            end
        end
    end

    // Priority levels on, legacy single level at reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            levelsOn_ff <= `PEP_RST_CTRL;                                 // [RULE17]
        end else if (wrCtrl) begin
            levelsOn_ff <= busReq.wdata[`PEP_BIT_LEVELS_ON];              // [RULE17]
        end
    end

    // ----------------------------------------
    // Named fields, absent bits forced low
    // ----------------------------------------
    // Enable two
    logic oscFailEn;
    logic comparatorEn;
    logic ethernetEn;
    logic busCollisionOneEn;
    logic timerThreeOvfEn;
    logic capcmpTwoEn;
    assign oscFailEn         = enTwo_ff[7];                               // [RULE12]
    assign comparatorEn      = enTwo_ff[6];
    assign ethernetEn        = enTwo_ff[5];
    assign busCollisionOneEn = enTwo_ff[3];
    assign timerThreeOvfEn   = enTwo_ff[1];
    assign capcmpTwoEn       = enTwo_ff[0];

    // Enable three
    logic syncSerialTwoEn;
    logic busCollisionTwoEn;
    logic asyncTwoRxEn;
    logic asyncTwoTxEn;
    logic timerFourMatchEn;
    logic capcmpFiveEn;
    logic capcmpFourEn;
    logic capcmpThreeEn;
    assign syncSerialTwoEn   = enThree_ff[7] & MASK_THREE[7];             // [RULE9] [RULE13]
    assign busCollisionTwoEn = enThree_ff[6] & MASK_THREE[6];             // [RULE9]
    assign asyncTwoRxEn      = enThree_ff[5] & MASK_THREE[5];             // [RULE10]
    assign asyncTwoTxEn      = enThree_ff[4] & MASK_THREE[4];             // [RULE10]
    assign timerFourMatchEn  = enThree_ff[3];
    assign capcmpFiveEn      = enThree_ff[2];
    assign capcmpFourEn      = enThree_ff[1];
    assign capcmpThreeEn     = enThree_ff[0];

    // Priority one
    logic parallelSlavePrio;
    logic converterPrio;
    logic asyncOneRxPrio;
    logic asyncOneTxPrio;
    logic syncSerialOnePrio;
    logic capcmpOnePrio;
    logic timerTwoMatchPrio;
    logic timerOneOvfPrio;
    assign parallelSlavePrio = prioOne_ff[`PEP_BIT_PSP] & maskOneNow[`PEP_BIT_PSP]; // [RULE11] [RULE14]
    assign converterPrio     = prioOne_ff[6];
    assign asyncOneRxPrio    = prioOne_ff[5];
    assign asyncOneTxPrio    = prioOne_ff[4];
    assign syncSerialOnePrio = prioOne_ff[3];
    assign capcmpOnePrio     = prioOne_ff[2];
    assign timerTwoMatchPrio = prioOne_ff[1];
    assign timerOneOvfPrio   = prioOne_ff[0];

    // Priority two
    logic oscFailPrio;
    logic comparatorPrio;
    logic ethernetPrio;
    logic busCollisionOnePrio;
    logic timerThreeOvfPrio;
    logic capcmpTwoPrio;
    assign oscFailPrio         = prioTwo_ff[7];                           // [RULE15]
    assign comparatorPrio      = prioTwo_ff[6];
    assign ethernetPrio        = prioTwo_ff[5];
    assign busCollisionOnePrio = prioTwo_ff[3];
    assign timerThreeOvfPrio   = prioTwo_ff[1];
    assign capcmpTwoPrio       = prioTwo_ff[0];

    // Priority three
    logic syncSerialTwoPrio;
    logic busCollisionTwoPrio;
    logic asyncTwoRxPrio;
    logic asyncTwoTxPrio;
    logic timerFourMatchPrio;
    logic capcmpFivePrio;
    logic capcmpFourPrio;
    logic capcmpThreePrio;
    assign syncSerialTwoPrio   = prioThree_ff[7] & MASK_THREE[7];         // [RULE9] [RULE16]
    assign busCollisionTwoPrio = prioThree_ff[6] & MASK_THREE[6];         // [RULE9]
    assign asyncTwoRxPrio      = prioThree_ff[5] & MASK_THREE[5];         // [RULE10]
    assign asyncTwoTxPrio      = prioThree_ff[4] & MASK_THREE[4];         // [RULE10]
    assign timerFourMatchPrio  = prioThree_ff[3];
    assign capcmpFivePrio      = prioThree_ff[2];
    assign capcmpFourPrio      = prioThree_ff[1];
    assign capcmpThreePrio     = prioThree_ff[0];

    // ----------------------------------------
    // Request routing
    // ----------------------------------------
    logic [23:0] effEnable;
    logic [23:0] effPrio;
    logic [23:0] pending;
    logic        nxt_reqHigh;
    logic        nxt_reqLow;

    assign effEnable = {enThree_ff & MASK_THREE, enTwo_ff & MASK_TWO, enableOne};
    assign effPrio   = {prioThree_ff & MASK_THREE, prioTwo_ff & MASK_TWO, prioOne_ff & maskOneNow};
    assign pending   = srcFlags & effEnable;                              // [RULE1] [RULE18]

    always_comb begin
        if (levelsOn_ff) begin
            nxt_reqHigh = |(pending & effPrio);                           // [RULE2] [RULE3]
            nxt_reqLow  = |(pending & ~effPrio);                          // [RULE2]
        end else begin
            nxt_reqHigh = |pending;                                       // [RULE3] [RULE17]
            nxt_reqLow  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reqHigh_ff <= 1'b0;
            reqLow_ff  <= 1'b0;
        end else begin
            reqHigh_ff <= nxt_reqHigh;                                    // [RULE18]
            reqLow_ff  <= nxt_reqLow;                                     // [RULE18]
        end
    end

    // ----------------------------------------
    // Event status, mask and interrupt
    // ----------------------------------------
    logic [2:0] events;
    logic       rsvdMisuse;

    // Reserved bit written against its documented value
    assign rsvdMisuse = (wrEnTwo && busReq.wdata[`PEP_BIT_RESERVED])
                     || (wrPrioTwo && !busReq.wdata[`PEP_BIT_RESERVED]); // [RULE6] [RULE7]

    always_comb begin
        events                 = 3'h0;
        events[`PEP_STS_HIGH]  = nxt_reqHigh && !reqHigh_ff;
        events[`PEP_STS_LOW]   = nxt_reqLow && !reqLow_ff;
        events[`PEP_STS_RSVD]  = rsvdMisuse;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= `PEP_RST_STATUS;
        end else if (wrStatus) begin
            status_ff <= (status_ff & ~busReq.wdata[2:0]) | events;
        end else begin
            status_ff <= status_ff | events;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_ff <= `PEP_RST_MASK;
        end else if (wrMask) begin
            mask_ff <= busReq.wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ----------------------------------------
    // Read port, data valid one cycle after strobe
    // ----------------------------------------
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                `PEP_OFF_EN_TWO: begin
                    nxt_rdata = {oscFailEn, comparatorEn, ethernetEn, enTwo_ff[`PEP_BIT_RESERVED],
                                 busCollisionOneEn, 1'b0, timerThreeOvfEn, capcmpTwoEn};  // [RULE8]
                end
                `PEP_OFF_EN_THREE: begin
                    nxt_rdata = {syncSerialTwoEn, busCollisionTwoEn, asyncTwoRxEn, asyncTwoTxEn,
                                 timerFourMatchEn, capcmpFiveEn, capcmpFourEn, capcmpThreeEn}; // [RULE19]
                end
                `PEP_OFF_PRIO_ONE: begin
                    nxt_rdata = {parallelSlavePrio, converterPrio, asyncOneRxPrio, asyncOneTxPrio,
                                 syncSerialOnePrio, capcmpOnePrio, timerTwoMatchPrio, timerOneOvfPrio}; // [RULE19]
                end
                `PEP_OFF_PRIO_TWO: begin
                    nxt_rdata = {oscFailPrio, comparatorPrio, ethernetPrio, prioTwo_ff[`PEP_BIT_RESERVED],
                                 busCollisionOnePrio, 1'b0, timerThreeOvfPrio, capcmpTwoPrio};  // [RULE8]
                end
                `PEP_OFF_PRIO_THREE: begin
                    nxt_rdata = {syncSerialTwoPrio, busCollisionTwoPrio, asyncTwoRxPrio, asyncTwoTxPrio,
                                 timerFourMatchPrio, capcmpFivePrio, capcmpFourPrio, capcmpThreePrio}; // [RULE19]
                end
                `PEP_OFF_RESET_CAUSE: nxt_rdata = {levelsOn_ff, 7'h00};
                `PEP_OFF_STATUS:      nxt_rdata = {5'h00, status_ff};
                `PEP_OFF_MASK:        nxt_rdata = {5'h00, mask_ff};
                default:              nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule

// ---- rtl/pep_cfg.svh ----
`ifndef PEP_CFG_SVH
`define PEP_CFG_SVH

// ----------------------------------------
// Register offsets (word index on the port)
// ----------------------------------------
`define PEP_OFF_EN_TWO      4'h0
`define PEP_OFF_EN_THREE    4'h1
`define PEP_OFF_PRIO_ONE    4'h2
`define PEP_OFF_PRIO_TWO    4'h3
`define PEP_OFF_PRIO_THREE  4'h4
`define PEP_OFF_RESET_CAUSE 4'h5
`define PEP_OFF_STATUS      4'h6
`define PEP_OFF_MASK        4'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PEP_RST_ENABLE      8'h00
`define PEP_RST_PRIO        8'hFF
`define PEP_RST_CTRL        1'b0
`define PEP_RST_STATUS      3'h0
`define PEP_RST_MASK        3'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PEP_BIT_LEVELS_ON   7
`define PEP_BIT_RESERVED    4
`define PEP_BIT_UNIMPL      2
`define PEP_BIT_PSP         7
`define PEP_STS_HIGH        0
`define PEP_STS_LOW         1
`define PEP_STS_RSVD        2

// ----------------------------------------
// Implemented-bit masks per package
// ----------------------------------------
`define PEP_MASK_TWO        8'hFB
`define PEP_MASK_THREE_BASE 8'h0F
`define PEP_MASK_THREE_80   8'h30
`define PEP_MASK_THREE_100  8'hC0
`define PEP_MASK_ONE_BASE   8'h7F
`define PEP_MASK_ONE_PSP    8'h80

`endif

// ---- rtl/pep_pkg.sv ----
package pep_pkg;

    // Register bus request from the core
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pep_bus_req_t;

    // Per-source flags or enables, one byte per register group
    typedef struct packed {
        logic [7:0] grpThree;
        logic [7:0] grpTwo;
        logic [7:0] grpOne;
    } pep_src_t;

endpackage

// ---- tb/pep_irq_enable_priority_assertions.sv ----
`timescale 1ns/10ps
`include "pep_cfg.svh"
module pep_irq_enable_priority_chk (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  reset_n,
    // Register port
    input wire pep_pkg::pep_bus_req_t busReq,
    input wire logic [7:0]            rdata_ff,
    // Peripheral side
    input wire pep_pkg::pep_src_t     srcFlags,
    input wire logic [7:0]            enableOne,
    input wire logic                  controllerMode,
    // Core side
    input wire logic                  reqHigh_ff,
    input wire logic                  reqLow_ff,
    input wire logic                  levelsOn_ff,
    input wire logic                  irq_ff
);
    import pep_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rdAt(logic [3:0] a);
        busReq.rd && busReq.addr == a;
    endsequence
    sequence ctrlWr;
        busReq.wr && busReq.addr == `PEP_OFF_RESET_CAUSE;
    endsequence
    AST_RDATA_IDLE: assert property (!busReq.rd |=> rdata_ff == 8'h00)
        else $error("read data not idle");
    AST_UNMAPPED: assert property (busReq.rd && busReq.addr[3] |=> rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    AST_UNIMPL_BIT: assert property (rdAt(`PEP_OFF_EN_TWO) or rdAt(`PEP_OFF_PRIO_TWO) |=> !rdata_ff[2])
        else $error("unimplemented bit reads one");
    AST_PSP_ABSENT: assert property (rdAt(`PEP_OFF_PRIO_ONE) ##0 !controllerMode |=> !rdata_ff[7])
        else $error("parallel slave priority visible");
    AST_CTRL_READ: assert property (rdAt(`PEP_OFF_RESET_CAUSE) |=> rdata_ff == {levelsOn_ff, 7'h00})
        else $error("control read wrong");
    AST_CTRL_WRITE: assert property (ctrlWr |=> levelsOn_ff == $past(busReq.wdata[7]))
        else $error("levels bit not written");
    AST_LEGACY_NO_LOW: assert property (!levelsOn_ff [*2] |-> !reqLow_ff)
        else $error("low request with levels off");
    AST_NO_SOURCE: assert property ($past(reset_n) && $past(srcFlags) == 24'h0 |-> !reqHigh_ff && !reqLow_ff)
        else $error("request without flag");
    AST_LEGACY_HIGH: assert property ($past(reset_n) && !$past(levelsOn_ff)
        && $past(|(srcFlags.grpOne & enableOne)) |-> reqHigh_ff)
        else $error("enabled source not high in legacy mode");
endmodule

// ---- tb/pep_periph_model.sv ----
`timescale 1ns/10ps
module pep_periph_model (
    // Clock and reset
    input wire logic           clk,
    input wire logic           reset_n,
    // Source events from bench
    input wire logic [23:0]    raise,
    // Level flags toward the block
    output pep_pkg::pep_src_t  srcFlags
);
    import pep_pkg::*;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srcFlags <= '0;
        end else begin
            srcFlags <= raise;
        end
    end
endmodule

// ---- tb/test_pep_irq_enable_priority.sv ----
`timescale 1ns/10ps
`include "pep_cfg.svh"
module test_pep_irq_enable_priority;
    import pep_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    pep_bus_req_t busReq = '0;
    logic [7:0] enableOne = 8'h00;
    logic controllerMode = 1'b1;
    logic [23:0] raise = 24'h0;
    logic rdPend = 1'b0;
    logic [7:0] rdata_ff, d;
    logic reqHigh_ff, reqLow_ff, levelsOn_ff, irq_ff;
    logic [23:0] pv;
    pep_src_t srcFlags;
    logic [7:0] expQ[$];
    int errCount = 0;
    int comparisons = 0;
    // Address, and-mask, or-mask, read mask
    logic [31:0] tbl [7] = '{32'h00EF00FB, 32'h01FF00FF, 32'h02FF00FF, 32'h03FF10FB,
                             32'h04FF00FF, 32'h05800080, 32'h07070007};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hFF, 8'hFB, 8'hFF, 8'h00, 8'h00, 8'h00};
    always #25 clk = ~clk;
    pep_periph_model peri (.clk, .reset_n, .raise, .srcFlags);
    pep_irq_enable_priority #(.PIN_COUNT(100)) dut (.clk, .reset_n, .busReq, .rdata_ff, .srcFlags,
        .enableOne, .controllerMode, .reqHigh_ff, .reqLow_ff, .levelsOn_ff, .irq_ff);
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task check(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            errCount++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wrapUp;
        if (errCount == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        busReq.addr <= a;
        busReq.wdata <= v;
        busReq.wr <= 1'b1;
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        busReq.rd <= 1'b0;
    endtask
    task settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task reqChk(input logic h, input logic l);
        settle;
        check({7'h00, reqHigh_ff}, {7'h00, h});
        check({7'h00, reqLow_ff}, {7'h00, l});
    endtask
    task irqChk(input logic e);
        settle;
        check({7'h00, irq_ff}, {7'h00, e});
    endtask
    always @(posedge clk) begin
        if (rdPend) begin
            check(rdata_ff, expQ.pop_front());
        end
        rdPend <= busReq.rd;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        wrapUp;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(66));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), (i < 8) ? rv[i[2:0]] : 8'h00);
        end
        for (int i = 0; i < 7; i++) begin
            d = (8'($urandom()) & tbl[i][23:16]) | tbl[i][15:8];
            wr(tbl[i][27:24], d);
            rd(tbl[i][27:24], d & tbl[i][7:0]);
        end
        wr(`PEP_OFF_PRIO_ONE, 8'hFF);
        controllerMode <= 1'b0;
        rd(`PEP_OFF_PRIO_ONE, 8'h7F);
        controllerMode <= 1'b1;
        rd(`PEP_OFF_PRIO_ONE, 8'hFF);
        pv = {8'($urandom()), 8'($urandom()) | 8'h10, (8'($urandom()) & 8'hFE) | 8'h02};
        wr(`PEP_OFF_PRIO_ONE, pv[7:0]);
        wr(`PEP_OFF_PRIO_TWO, pv[15:8]);
        wr(`PEP_OFF_PRIO_THREE, pv[23:16]);
        wr(`PEP_OFF_MASK, 8'h03);
        // Levels on, levels off, enables off
        for (int m = 0; m < 3; m++) begin
            wr(`PEP_OFF_RESET_CAUSE, (m == 0) ? 8'h80 : 8'h00);
            enableOne <= (m == 2) ? 8'h00 : 8'hFF;
            wr(`PEP_OFF_EN_TWO, (m == 2) ? 8'h00 : 8'hEB);
            wr(`PEP_OFF_EN_THREE, (m == 2) ? 8'h00 : 8'hFF);
            check({7'h00, levelsOn_ff}, {7'h00, m == 0});
            for (int i = 0; i < 24; i++) begin
                if (i != 10 && i != 12) begin
                    raise <= 24'h1 << i;
                    reqChk((m == 0) ? pv[i] : (m == 1), m == 0 && !pv[i]);
                    raise <= 24'h0;
                    reqChk(1'b0, 1'b0);
                end
            end
        end
        irqChk(1'b1);
        rd(`PEP_OFF_STATUS, 8'h03);
        wr(`PEP_OFF_MASK, 8'h00);
        irqChk(1'b0);
        wr(`PEP_OFF_MASK, 8'h03);
        wr(`PEP_OFF_STATUS, 8'h01);
        rd(`PEP_OFF_STATUS, 8'h02);
        irqChk(1'b1);
        wr(`PEP_OFF_STATUS, 8'h02);
        irqChk(1'b0);
        // Reserved bit misuse is flagged
        wr(`PEP_OFF_EN_TWO, 8'h10);
        rd(`PEP_OFF_EN_TWO, 8'h10);
        rd(`PEP_OFF_STATUS, 8'h04);
        wr(`PEP_OFF_STATUS, 8'h04);
        wr(`PEP_OFF_PRIO_TWO, 8'h00);
        rd(`PEP_OFF_STATUS, 8'h04);
        repeat (4) @(posedge clk);
        wrapUp;
    end
endmodule
bind pep_irq_enable_priority pep_irq_enable_priority_chk u_chk (.clk(clk), .reset_n(reset_n), .busReq(busReq),
    .rdata_ff(rdata_ff), .srcFlags(srcFlags), .enableOne(enableOne), .controllerMode(controllerMode),
    .reqHigh_ff(reqHigh_ff), .reqLow_ff(reqLow_ff), .levelsOn_ff(levelsOn_ff), .irq_ff(irq_ff));
